// [rtl/tki_keyboard_input.sv]
// keyboard input logic with register access over axi4-lite
`timescale 1ns/1ps
module tki_keyboard_input (
   input wire logic aclk,
   input wire logic aresetn,
   // register bus
   input wire logic [tki_pkg::ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [tki_pkg::ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // keyboard character, function key and button lines, low for one
   input wire logic [6:0] key_bits_n,
   input wire logic character_key_strobe_n,
   input wire logic function_key_strobe_n,
   input wire logic repeat_key_n,
   input wire logic tab_key_n,
   input wire logic control_key_n,
   input wire logic shift_key_n,
   input wire logic transmit_key_n,
   input wire logic up_key_n,
   input wire logic print_key_n,
   input wire logic left_key_n,
   input wire logic home_key_n,
   input wire logic right_key_n,
   input wire logic down_key_n,
   input wire logic clear_foreground_key_n,
   input wire logic insert_char_key_n,
   input wire logic delete_char_key_n,
   input wire logic clear_full_key_n,
   input wire logic insert_line_key_n,
   input wire logic delete_line_key_n,
   input wire logic receive_button_n,
   input wire logic local_button_n,
   input wire logic break_button_n,
   input wire logic reset_button_n,
   // lamps, low to light
   output logic receive_lamp_n,
   output logic transmit_lamp_n,
   output logic print_lamp_n,
   output logic local_lamp_n,
   // toward refresh memory
   output logic [6:0] memory_code,
   output logic memory_code_bit_eight,
   output logic intensity_select,
   output logic intensity_select_n,
   // decoded function levels
   output logic shifted_full_clear,
   output logic partial_erase_flag,
   output logic print_flag,
   output logic transmit_command,
   output logic case_select_level,
   output logic control_key_level,
   output logic return_key_enable,
   output logic return_flag,
   output logic alnum_flag,
   output logic down_or_return_flag,
   output logic expansion_flag,
   output logic compression_flag,
   output logic insert_line_flag_n,
   output logic home_flag,
   output logic repeat_process
);
   logic [tki_pkg::SYNC_W-1:0] sync_out;
   logic [6:0] kb_bits_n;
   logic chs_n;
   logic fns_n;
   logic [tki_pkg::FK_COUNT-1:0] fn_n;
   logic [3:0] pb_n;
   logic [tki_pkg::FK_COUNT-1:0] fn_low;
   logic [tki_pkg::FK_COUNT-1:0] fn_low_q;
   logic [tki_pkg::FK_COUNT-1:0] fn_press;
   logic chs_low_q;
   logic char_evt;
   logic [6:0] key_code;
   logic cr_now;
   logic cr_evt;
   logic any_fn;
   logic shift;
   logic arrows;
   logic repeat_cond;
   logic kb_reset;
   logic restore_pulse;
   logic [tki_pkg::FL_COUNT-1:0] flag;
   logic [tki_pkg::FL_COUNT-1:0] flag_set;
   logic [tki_pkg::FL_COUNT-1:0] flag_clr;
   logic [6:0] code;
   logic [3:0] lamp_on;
   logic aw_held;
   logic w_held;
   logic [tki_pkg::ADDR_W-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic do_write;

   function automatic logic addr_ok(input logic [tki_pkg::ADDR_W-1:0] a);
      addr_ok = (a[1:0] == 2'h0) && (a <= tki_pkg::REG_LAST);
   endfunction

   function automatic logic [31:0] read_word(
      input logic [tki_pkg::ADDR_W-1:0] a
   );
      read_word = 32'h00000000;
      case (a)
         tki_pkg::REG_CONTROL: read_word[3:0] = lamp_on;
         tki_pkg::REG_FLAGS: read_word[tki_pkg::FL_COUNT-1:0] = flag;
         tki_pkg::REG_CODE: read_word[6:0] = code;
         tki_pkg::REG_PANEL: read_word[5:0] = {~fns_n, ~chs_n, ~pb_n};
         default: read_word = 32'h00000000;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // synchronise all keyboard and panel inputs, not the register bus
   tki_sync #(
      .WIDTH(tki_pkg::SYNC_W),
      .IDLE(tki_pkg::SYNC_IDLE)
   ) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .async_in({reset_button_n, break_button_n, local_button_n,
         receive_button_n, delete_line_key_n, insert_line_key_n,
         clear_full_key_n, delete_char_key_n, insert_char_key_n,
         clear_foreground_key_n, down_key_n, right_key_n, home_key_n,
         left_key_n, print_key_n, up_key_n, transmit_key_n, shift_key_n,
         control_key_n, tab_key_n, repeat_key_n, function_key_strobe_n,
         character_key_strobe_n, key_bits_n}),
      .sync_out(sync_out)
   );

   assign kb_bits_n = sync_out[6:0];
   assign chs_n = sync_out[7];
   assign fns_n = sync_out[8];
   assign fn_n = sync_out[25:9];
   assign pb_n = sync_out[29:26];

   assign kb_reset = !aresetn || restore_pulse;

   ////////////////////////////////////////////////////////////////////////
   // key line valid only under strobe
   assign fn_low = ~fn_n & {tki_pkg::FK_COUNT{~fns_n}};
   // edge against the previous sample, so a held key acts once
   assign fn_press = fn_low & ~fn_low_q;
   assign char_evt = ~chs_n & ~chs_low_q;
   assign key_code = ~kb_bits_n;
   assign cr_now = (key_code == tki_pkg::CODE_RETURN);
   assign cr_evt = char_evt & cr_now;
   assign any_fn = |(fn_press & ~tki_pkg::FK_MODIFIER_MASK);
   assign shift = fn_low[tki_pkg::FK_SHIFT];
   assign arrows = fn_low[tki_pkg::FK_UP] | fn_low[tki_pkg::FK_DOWN]
      | fn_low[tki_pkg::FK_LEFT] | fn_low[tki_pkg::FK_RIGHT];
   assign repeat_cond = fn_low[tki_pkg::FK_REPEAT] & (~chs_n | arrows);

   // restore keeps edge history, so a key held across it is not re-acted
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fn_low_q <= '0;
         chs_low_q <= 1'b0;
      end else begin
         fn_low_q <= fn_low;
         chs_low_q <= ~chs_n;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      flag_set = '0;
      flag_clr = '0;
      flag_set[tki_pkg::FL_FULL_CLEAR] = fn_press[tki_pkg::FK_CLEAR_FULL]
         & shift;
      flag_clr[tki_pkg::FL_FULL_CLEAR] = char_evt;
      flag_set[tki_pkg::FL_PARTIAL] = fn_press[tki_pkg::FK_CLEAR_FG] & shift;
      flag_clr[tki_pkg::FL_PARTIAL] = char_evt;
      flag_set[tki_pkg::FL_PRINT] = fn_press[tki_pkg::FK_PRINT] & shift;
      flag_clr[tki_pkg::FL_PRINT] = char_evt;
      flag_set[tki_pkg::FL_TRANSMIT] = fn_press[tki_pkg::FK_TRANSMIT] & shift;
      flag_clr[tki_pkg::FL_TRANSMIT] = char_evt;
      flag_set[tki_pkg::FL_CASE] = shift;
      flag_clr[tki_pkg::FL_CASE] = ~shift;
      flag_set[tki_pkg::FL_CONTROL] = fn_low[tki_pkg::FK_CONTROL];
      flag_clr[tki_pkg::FL_CONTROL] = ~fn_low[tki_pkg::FK_CONTROL];
      flag_set[tki_pkg::FL_RETURN_EN] = ~chs_n & cr_now;
      flag_clr[tki_pkg::FL_RETURN_EN] = ~(~chs_n & cr_now);
      flag_set[tki_pkg::FL_RETURN] = cr_evt;
      flag_clr[tki_pkg::FL_RETURN] = any_fn;
      // control is a modifier, alnum untouched
      flag_set[tki_pkg::FL_ALNUM] = char_evt;
      flag_clr[tki_pkg::FL_ALNUM] = any_fn;
      flag_set[tki_pkg::FL_DOWN_RETURN] = cr_evt | fn_press[tki_pkg::FK_DOWN];
      flag_clr[tki_pkg::FL_DOWN_RETURN] = (char_evt & ~cr_now) | any_fn;
      flag_set[tki_pkg::FL_EXPANSION] = char_evt
         & fn_low[tki_pkg::FK_INSERT_CHAR];
      flag_clr[tki_pkg::FL_EXPANSION] = char_evt;
      flag_set[tki_pkg::FL_COMPRESSION] = fn_press[tki_pkg::FK_DELETE_CHAR];
      flag_clr[tki_pkg::FL_COMPRESSION] = char_evt;
      flag_set[tki_pkg::FL_INSERT_LINE] = fn_press[tki_pkg::FK_INSERT_LINE];
      flag_clr[tki_pkg::FL_INSERT_LINE] = char_evt;
      flag_set[tki_pkg::FL_HOME] = fn_press[tki_pkg::FK_HOME];
      flag_clr[tki_pkg::FL_HOME] = char_evt;
      // repeat with character or cursor key
      flag_set[tki_pkg::FL_REPEAT] = repeat_cond;
      flag_clr[tki_pkg::FL_REPEAT] = ~repeat_cond;
   end

   // set wins over clear in the same cycle
   always_ff @(posedge aclk) begin
      if (kb_reset) begin
         flag <= tki_pkg::FLAGS_RESET;
      end else begin
         flag <= flag_set | (flag & ~flag_clr);
      end
   end

   always_ff @(posedge aclk) begin
      if (kb_reset) begin
         code <= tki_pkg::CODE_RESET;
      end else if (flag_set[tki_pkg::FL_FULL_CLEAR]) begin
         code <= tki_pkg::CODE_SPACE;
      end else if (char_evt) begin
         code <= key_code;
      end
   end

   assign memory_code = code ^ tki_pkg::MEM_INVERT_MASK;
   assign memory_code_bit_eight = 1'b1;
   assign intensity_select = 1'b1;
   assign intensity_select_n = 1'b0;

   assign shifted_full_clear = flag[tki_pkg::FL_FULL_CLEAR];
   assign partial_erase_flag = flag[tki_pkg::FL_PARTIAL];
   assign print_flag = flag[tki_pkg::FL_PRINT];
   assign transmit_command = flag[tki_pkg::FL_TRANSMIT];
   assign case_select_level = flag[tki_pkg::FL_CASE];
   assign control_key_level = flag[tki_pkg::FL_CONTROL];
   assign return_key_enable = flag[tki_pkg::FL_RETURN_EN];
   assign return_flag = flag[tki_pkg::FL_RETURN];
   assign alnum_flag = flag[tki_pkg::FL_ALNUM];
   assign down_or_return_flag = flag[tki_pkg::FL_DOWN_RETURN];
   assign expansion_flag = flag[tki_pkg::FL_EXPANSION];
   assign compression_flag = flag[tki_pkg::FL_COMPRESSION];
   assign insert_line_flag_n = ~flag[tki_pkg::FL_INSERT_LINE];
   assign home_flag = flag[tki_pkg::FL_HOME];
   assign repeat_process = flag[tki_pkg::FL_REPEAT];

   assign receive_lamp_n = ~lamp_on[tki_pkg::CTL_LAMP_RECEIVE];
   assign transmit_lamp_n = ~lamp_on[tki_pkg::CTL_LAMP_TRANSMIT];
   assign print_lamp_n = ~lamp_on[tki_pkg::CTL_LAMP_PRINT];
   assign local_lamp_n = ~lamp_on[tki_pkg::CTL_LAMP_LOCAL];

   ////////////////////////////////////////////////////////////////////////
   // register bus: address and data may arrive in either order
   assign awready = !aw_held;
   assign wready = !w_held;
   assign arready = !rvalid;
   assign do_write = aw_held && w_held && !bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         bvalid <= 1'b0;
         bresp <= tki_pkg::RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            aw_held <= 1'b1;
            aw_addr <= awaddr;
         end else if (do_write) begin
            aw_held <= 1'b0;
         end
         if (wvalid && wready) begin
            w_held <= 1'b1;
            w_data <= wdata;
            w_strb <= wstrb;
         end else if (do_write) begin
            w_held <= 1'b0;
         end
         if (do_write) begin
            bvalid <= 1'b1;
            bresp <= addr_ok(aw_addr) ? tki_pkg::RESP_OKAY
               : tki_pkg::RESP_SLVERR;
         end else if (bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // restore is a one-cycle pulse, lamps survive it on purpose
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lamp_on <= tki_pkg::CTL_LAMP_RESET;
         restore_pulse <= 1'b0;
      end else begin
         restore_pulse <= 1'b0;
         if (do_write && aw_addr == tki_pkg::REG_CONTROL
            && w_strb[0]) begin
            lamp_on <= w_data[3:0];
            restore_pulse <= w_data[tki_pkg::CTL_RESTORE];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= tki_pkg::RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rdata <= read_word(araddr);
         rresp <= addr_ok(araddr) ? tki_pkg::RESP_OKAY : tki_pkg::RESP_SLVERR;
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   a_full_clear_set: assert property (
      @(posedge aclk) disable iff (kb_reset)
      fn_press[tki_pkg::FK_CLEAR_FULL] && shift |=> shifted_full_clear)
      else $error("full clear flag not set");
   a_unshift_clear: assert property (
      @(posedge aclk) disable iff (kb_reset)
      fn_press[tki_pkg::FK_CLEAR_FULL] && !shift && !shifted_full_clear
      |=> !shifted_full_clear)
      else $error("unshifted clear set the flag");
   a_space_load: assert property (
      @(posedge aclk) disable iff (kb_reset)
      flag_set[tki_pkg::FL_FULL_CLEAR] |=> memory_code == 7'h7F)
      else $error("space not presented after shifted clear");
   a_code_sense: assert property (
      @(posedge aclk) disable iff (kb_reset)
      char_evt && !flag_set[tki_pkg::FL_FULL_CLEAR]
      |=> memory_code[5] == $past(~kb_bits_n[5])
      && memory_code[0] == $past(kb_bits_n[0]))
      else $error("memory code sense wrong");
   a_print_clear: assert property (
      @(posedge aclk) disable iff (kb_reset)
      char_evt && !fn_press[tki_pkg::FK_PRINT] |=> !print_flag)
      else $error("print flag survived a character");
   a_return_flags: assert property (
      @(posedge aclk) disable iff (kb_reset)
      cr_evt |=> return_flag && alnum_flag && down_or_return_flag)
      else $error("return flags not set");
   a_expansion_set: assert property (
      @(posedge aclk) disable iff (kb_reset)
      char_evt |=> expansion_flag == $past(fn_low[tki_pkg::FK_INSERT_CHAR]))
      else $error("expansion flag wrong after character");
   a_repeat_alone: assert property (
      @(posedge aclk) disable iff (kb_reset)
      fn_low[tki_pkg::FK_REPEAT] && chs_n && !arrows |=> !repeat_process)
      else $error("repeat process high with repeat alone");
   a_alnum_control: assert property (
      @(posedge aclk) disable iff (kb_reset)
      alnum_flag && fn_press == (17'h1 << tki_pkg::FK_CONTROL) |=> alnum_flag)
      else $error("control key disturbed alnum");
   a_case_level: assert property (
      @(posedge aclk) disable iff (kb_reset)
      ##1 case_select_level == $past(shift))
      else $error("case select does not follow shift");
   a_insert_line: assert property (
      @(posedge aclk) disable iff (kb_reset)
      fn_press[tki_pkg::FK_INSERT_LINE] |=> !insert_line_flag_n)
      else $error("insert line flag not low");
endmodule // tki_keyboard_input

// [rtl/tki_pkg.sv]
// constants for the terminal keyboard input logic
//
// Summary of operation
// - a low function key line counts only while the function strobe is low.
// - lamp outputs go low to light a lamp and high to extinguish it.
// - character code into the data register is true-sense, all low when idle.
// - memory code bits are inverted, except bit five, kept true-sense.
// - shifted full-clear keystroke loads the space character toward memory.
// - the eighth memory data bit stays high for keyed characters.
// - keyed characters get foreground: true output high, complement low.
// - shifted clear sets the full-clear flag; next character resets it.
// - shifted clear-foreground sets partial erase; a character resets it.
// - shifted print sets the print flag; next character clears it.
// - case select level is high while either shift key is held.
// - return key gives enable while held; sets return, alnum, down flags.
// - character with insert-character held sets expansion; alone clears.
// - delete-character sets compression; next character clears it.
// - control key alone keeps alnum flag; control level high while held.
// - repeat process high only with repeat plus character or cursor key.
// - insert-line drives its active-low flag low until next character.
// - home key sets the home flag; next character clears it.
package tki_pkg;
   // register map, byte addresses on the register bus
   localparam int ADDR_W = 5;
   localparam logic [4:0] REG_CONTROL = 5'h00;
   localparam logic [4:0] REG_FLAGS = 5'h04;
   localparam logic [4:0] REG_CODE = 5'h08;
   localparam logic [4:0] REG_PANEL = 5'h0C;
   localparam logic [4:0] REG_LAST = 5'h0C;
   // control register fields
   localparam int CTL_LAMP_RECEIVE = 0;
   localparam int CTL_LAMP_TRANSMIT = 1;
   localparam int CTL_LAMP_PRINT = 2;
   localparam int CTL_LAMP_LOCAL = 3;
   localparam int CTL_RESTORE = 4;
   localparam logic [3:0] CTL_LAMP_RESET = 4'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // function key line positions
   localparam int FK_REPEAT = 0;
   localparam int FK_TAB = 1;
   localparam int FK_CONTROL = 2;
   localparam int FK_SHIFT = 3;
   localparam int FK_TRANSMIT = 4;
   localparam int FK_UP = 5;
   localparam int FK_PRINT = 6;
   localparam int FK_LEFT = 7;
   localparam int FK_HOME = 8;
   localparam int FK_RIGHT = 9;
   localparam int FK_DOWN = 10;
   localparam int FK_CLEAR_FG = 11;
   localparam int FK_INSERT_CHAR = 12;
   localparam int FK_DELETE_CHAR = 13;
   localparam int FK_CLEAR_FULL = 14;
   localparam int FK_INSERT_LINE = 15;
   localparam int FK_DELETE_LINE = 16;
   localparam int FK_COUNT = 17;
   // keys that do not end a return sequence
   localparam logic [16:0] FK_MODIFIER_MASK = 17'h0000D;
   // latched flag positions, also the flags register layout
   localparam int FL_FULL_CLEAR = 0;
   localparam int FL_PARTIAL = 1;
   localparam int FL_PRINT = 2;
   localparam int FL_TRANSMIT = 3;
   localparam int FL_CASE = 4;
   localparam int FL_CONTROL = 5;
   localparam int FL_RETURN_EN = 6;
   localparam int FL_RETURN = 7;
   localparam int FL_ALNUM = 8;
   localparam int FL_DOWN_RETURN = 9;
   localparam int FL_EXPANSION = 10;
   localparam int FL_COMPRESSION = 11;
   localparam int FL_INSERT_LINE = 12;
   localparam int FL_HOME = 13;
   localparam int FL_REPEAT = 14;
   localparam int FL_COUNT = 15;
   localparam logic [14:0] FLAGS_RESET = 15'h0000;
   // character codes
   localparam logic [6:0] CODE_RESET = 7'h00;
   localparam logic [6:0] CODE_SPACE = 7'h20;
   localparam logic [6:0] CODE_RETURN = 7'h0D;
   localparam logic [6:0] MEM_INVERT_MASK = 7'h5F;
   // synchroniser width and idle level (all inputs are active low)
   localparam int SYNC_W = 30;
   localparam logic [29:0] SYNC_IDLE = 30'h3FFFFFFF;
endpackage

// [rtl/tki_sync.sv]
// two-stage synchroniser for the keyboard and panel lines
`timescale 1ns/1ps
module tki_sync #(
   parameter int WIDTH = 30,
   parameter logic [WIDTH-1:0] IDLE = '1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;

   // stage1 feeds only the second stage
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stage1 <= IDLE;
         sync_out <= IDLE;
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end
endmodule // tki_sync

// [tb/tki_keyboard_model.sv]
// keyboard unit model: key switches, pushbuttons and strobes
`timescale 1ns/1ps
module tki_keyboard_model (
   input wire logic [16:0] fn_down,
   input wire logic [6:0] code,
   input wire logic char_down,
   input wire logic strobe_fault,
   input wire logic [3:0] buttons,
   output logic [16:0] fk_n,
   output logic [6:0] key_bits_n,
   output logic character_key_strobe_n,
   output logic function_key_strobe_n,
   output logic [3:0] button_n
);
   assign fk_n = ~fn_down;
   // function strobe with any function key
   // fault mode holds it up so that held lines must be ignored
   assign function_key_strobe_n = ~(|fn_down) | strobe_fault;
   assign character_key_strobe_n = ~char_down;
   // pull-ups take released code lines high
   assign key_bits_n = char_down ? ~code : 7'h7F;
   assign button_n = ~buttons;
endmodule // tki_keyboard_model

// [tb/tki_keyboard_input_test.sv]
// testbench for the keyboard input logic
`timescale 1ns/1ps
module tki_keyboard_input_test;
   typedef struct packed {
      logic [16:0] hold, key;
      logic [7:0] chr;
      logic [14:0] exp;
   } tki_row_t;
   // hold, key, valid+code, flags after release
   tki_row_t rows [21] = '{
      '{17'h0, 17'h0, 8'hC1, 15'h0100}, '{17'h0, 17'h04000, 8'h0, 15'h0},
      '{17'h0, 17'h00800, 8'h0, 15'h0}, '{17'h0, 17'h00040, 8'h0, 15'h0},
      '{17'h0, 17'h00010, 8'h0, 15'h0}, '{17'h0, 17'h01000, 8'h0, 15'h0},
      '{17'h8, 17'h04000, 8'h0, 15'h1}, '{17'h8, 17'h00800, 8'h0, 15'h3},
      '{17'h8, 17'h00040, 8'h0, 15'h7}, '{17'h8, 17'h00010, 8'h0, 15'hF},
      '{17'h0, 17'h02000, 8'h0, 15'h080F}, '{17'h0, 17'h00100, 8'h0, 15'h280F},
      '{17'h0, 17'h08000, 8'h0, 15'h380F}, '{17'h0, 17'h0, 8'hA0, 15'h0100},
      '{17'h0, 17'h0, 8'h8D, 15'h0380}, '{17'h0, 17'h00004, 8'h0, 15'h0380},
      '{17'h0, 17'h00100, 8'h0, 15'h2000}, '{17'h01000, 17'h0, 8'hC1, 15'h0500},
      '{17'h0, 17'h0, 8'hC1, 15'h0100}, '{17'h0, 17'h00400, 8'h0, 15'h0200},
      '{17'h0, 17'h0, 8'hC1, 15'h0100}};
   int arrow [4] = '{tki_pkg::FK_UP, tki_pkg::FK_LEFT, tki_pkg::FK_RIGHT,
      tki_pkg::FK_DOWN};
   int bad_count = 0, n_compared = 0;
   logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
   logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0, char_down = 1'b0;
   logic strobe_fault = 1'b0;
   logic [4:0] awaddr = 5'h00, araddr = 5'h00;
   logic [31:0] wdata = 32'h0, d;
   logic [3:0] wstrb = 4'hF, buttons = 4'h0;
   logic [16:0] fn_down = 17'h0;
   logic [6:0] code = 7'h00, mexp = 7'h5F;
   logic [1:0] r;
   wire awready, wready, bvalid, arready, rvalid;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [16:0] fk_n;
   wire [6:0] key_bits_n, memory_code;
   wire [3:0] button_n;
   wire character_key_strobe_n, function_key_strobe_n, receive_lamp_n;
   wire transmit_lamp_n, print_lamp_n, local_lamp_n, memory_code_bit_eight;
   wire intensity_select, intensity_select_n, shifted_full_clear, print_flag;
   wire partial_erase_flag, transmit_command, case_select_level, home_flag;
   wire control_key_level, return_key_enable, return_flag, alnum_flag;
   wire down_or_return_flag, expansion_flag, compression_flag, repeat_process;
   wire insert_line_flag_n, repeat_key_n, tab_key_n, control_key_n;
   wire shift_key_n, transmit_key_n, up_key_n, print_key_n, left_key_n;
   wire home_key_n, right_key_n, down_key_n, clear_foreground_key_n;
   wire insert_char_key_n, delete_char_key_n, clear_full_key_n;
   wire insert_line_key_n, delete_line_key_n, receive_button_n;
   wire local_button_n, break_button_n, reset_button_n;
   assign {delete_line_key_n, insert_line_key_n, clear_full_key_n,
      delete_char_key_n, insert_char_key_n, clear_foreground_key_n,
      down_key_n, right_key_n, home_key_n, left_key_n, print_key_n, up_key_n,
      transmit_key_n, shift_key_n, control_key_n, tab_key_n,
      repeat_key_n} = fk_n;
   assign {reset_button_n, break_button_n, local_button_n,
      receive_button_n} = button_n;
   wire [14:0] fl = {repeat_process, home_flag, ~insert_line_flag_n,
      compression_flag, expansion_flag, down_or_return_flag, alnum_flag,
      return_flag, return_key_enable, control_key_level, case_select_level,
      transmit_command, print_flag, partial_erase_flag, shifted_full_clear};
   wire [3:0] lamps_n = {receive_lamp_n, transmit_lamp_n, print_lamp_n,
      local_lamp_n};
   tki_keyboard_input i_tki_keyboard_input (.*);
   tki_keyboard_model i_tki_keyboard_model (.*);
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      if (bad_count == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // code settles before the strobe falls
   task automatic press(input logic [16:0] h, input logic [7:0] c);
      @(posedge aclk);
      fn_down <= h;
      if (c[7]) code <= c[6:0];
      repeat (2) @(posedge aclk);
      char_down <= c[7];
      repeat (6) @(posedge aclk);
   endtask
   task automatic strike(input logic [16:0] h, k, input logic [7:0] c);
      press(h, 8'h00);
      press(h | k, c);
      press(h, 8'h00);
      press(17'h0, 8'h00);
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] v);
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      forever #2 aclk = ~aclk;
   end
   initial begin
      #100000;
      bad_count++;
      finish_test();
   end
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      chk({fl, memory_code}, {15'h0, 7'h5F});
      chk(lamps_n, 4'hF);
      foreach (rows[i]) begin
         strike(rows[i].hold, rows[i].key, rows[i].chr);
         if (rows[i].chr[7]) mexp = rows[i].chr[6:0] ^ 7'h5F;
         if (rows[i].hold[3] && rows[i].key[14]) mexp = 7'h7F;
         chk(fl, rows[i].exp);
         chk(memory_code, mexp);
         chk({memory_code_bit_eight, intensity_select, intensity_select_n},
            3'b110);
      end
      press(17'h00008, 8'h00);
      chk(case_select_level, 1'b1);
      press(17'h00004, 8'h00);
      chk({case_select_level, control_key_level}, 2'b01);
      press(17'h0, 8'h8D);
      chk({control_key_level, return_key_enable}, 2'b01);
      press(17'h00001, 8'h00);
      chk({return_key_enable, repeat_process}, 2'b00);
      press(17'h00001, 8'hC1);
      chk(repeat_process, 1'b1);
      foreach (arrow[j]) begin
         press(17'h00001 | (17'h1 << arrow[j]), 8'h00);
         chk(repeat_process, 1'b1);
         press(17'h0, 8'h00);
      end
      strike(17'h0, 17'h0, 8'hC1);
      strobe_fault <= 1'b1;
      strike(17'h00008, 17'h04000, 8'h00);
      chk({fl, memory_code}, {15'h0100, 7'h1E});
      strobe_fault <= 1'b0;
      wr(tki_pkg::REG_CONTROL, 32'h00000001);
      chk({r, lamps_n}, {tki_pkg::RESP_OKAY, 4'h7});
      wr(tki_pkg::REG_CONTROL, 32'h0000000C);
      chk(lamps_n, 4'hC);
      wr(5'h10, 32'h0000000F);
      chk({r, lamps_n}, {tki_pkg::RESP_SLVERR, 4'hC});
      rd(tki_pkg::REG_FLAGS);
      chk({r, d[29:0]}, {tki_pkg::RESP_OKAY, 30'h100});
      buttons <= 4'h1;
      rd(tki_pkg::REG_PANEL);
      rd(tki_pkg::REG_PANEL);
      chk(d, 32'h00000001);
      rd(5'h10);
      chk({r, d[29:0]}, {tki_pkg::RESP_SLVERR, 30'h0});
      strike(17'h00008, 17'h04000, 8'h00);
      wr(tki_pkg::REG_CONTROL, 32'h00000013);
      repeat (4) @(posedge aclk);
      chk({fl, memory_code}, {15'h0, 7'h5F});
      chk(lamps_n, 4'h3);
      finish_test();
   end
endmodule // tki_keyboard_input_test
